// ===== acs_pkg.sv
// Package holding the calibration sequencer constants, register map and state codes.
package acs_pkg;
   // Sample path width.
   localparam int unsigned SAMPLE_W      = 14;
   // Register map of the serial control port.
   localparam logic [7:0]  CAL_STATE_ADDR = 8'hb6;
   localparam int unsigned CAL_DONE_BIT  = 0;
   localparam logic [7:0]  REG_ZERO      = 8'h00;
   // Timing figures as printed, in milliseconds, and the clock rate in MHz.
   localparam int unsigned CAL_TYP_MS    = 280;
   localparam int unsigned CAL_MAX_MS    = 550;
   localparam int unsigned CLK_MHZ       = 125;
   // Cycle counts derived from the figures; the longest time converts exactly, without rounding.
   localparam int unsigned CAL_TYP_CYC   = CAL_TYP_MS * CLK_MHZ * 1000;
   localparam int unsigned CAL_MAX_CYC   = (CAL_MAX_MS * CLK_MHZ * 1000);
   localparam int unsigned CNT_W         = 27;
   // Scrambler used to make the lanes toggle while calibration runs.
   localparam logic [SAMPLE_W-1:0] LFSR_SEED = 14'h1ace;
   localparam logic [SAMPLE_W-1:0] LFSR_TAPS = 14'h2803;
   localparam logic [SAMPLE_W-1:0] FULL_ONES = 14'h3fff;
   localparam logic [SAMPLE_W-1:0] FULL_ZERO = 14'h0000;

   // Sequencer states, Gray coded along hold, calibrate, run.
   typedef enum logic [1:0] {
      ACS_HOLD = 2'b00,
      ACS_CAL  = 2'b01,
      ACS_RUN  = 2'b11
   } acs_state_e;

   // Galois step of the lane scrambler.
   function automatic logic [SAMPLE_W-1:0] acs_lfsr_step(input logic [SAMPLE_W-1:0] v);
      acs_lfsr_step = v[0] ? ((v >> 1) ^ LFSR_TAPS) : (v >> 1);
   endfunction : acs_lfsr_step
endpackage : acs_pkg

// ===== acs_edge_sync.sv
// Two-stage synchroniser for the calibrate request line with a rising-edge pulse.
`timescale 1ns/1ps
module acs_edge_sync (
   input  wire logic core_clk,
   input  wire logic rstN,
   input  wire logic lineIn,
   output logic      lineSync,
   output logic      risePulse
);
   logic s1_q, s2_q, s3_q, rise_q;
   logic s1_d, s2_d, s3_d, rise_d;

   // The first stage feeds only the second; the edge is taken from later stages.
   always_comb begin
      s1_d   = lineIn;
      s2_d   = s1_q;
      s3_d   = s2_q;
      rise_d = s2_q & ~s3_q;
   end

   // Stages reset low so a line already high at reset release counts as an edge.
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         s1_q   <= 1'b0;
         s2_q   <= 1'b0;
         s3_q   <= 1'b0;
         rise_q <= 1'b0;
      end else begin
         s1_q   <= s1_d;
         s2_q   <= s2_d;
         s3_q   <= s3_d;
         rise_q <= rise_d;
      end
   end

   assign lineSync  = s2_q;
   assign risePulse = rise_q;
endmodule : acs_edge_sync

// ===== acs_top.sv
// Calibration sequencer: power-on hold, calibrate request line, status register, output clamp.
`timescale 1ns/1ps
module acs_top
   import acs_pkg::*;
#(
   parameter int unsigned CAL_CYCLES = acs_pkg::CAL_TYP_CYC
) (
   input  wire logic                        core_clk,
   input  wire logic                        nrst,
   input  wire logic                        analogSupplyOk,
   input  wire logic                        digitalSupplyOk,
   input  wire logic                        calReqNIn,
   output logic                             calReqNOut,
   output logic                             calReqNOe,
   input  wire logic                        regRd,
   input  wire logic [7:0]                  regAddr,
   output logic      [7:0]                  regRdData,
   output logic                             regRdValid,
   output logic                             regRdRefused,
   input  wire logic [acs_pkg::SAMPLE_W-1:0] sampleIn,
   input  wire logic                        overRangePos,
   input  wire logic                        overRangeNeg,
   output logic      [acs_pkg::SAMPLE_W-1:0] laneData,
   output logic                             laneValid
);
   import acs_pkg::*;

   // Reset release through two flip-flops; the rest of the design uses rstN.
   logic rstMeta_q, rstN_q;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_q <= 1'b0;
         rstN_q    <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstN_q    <= rstMeta_q;
      end
   end
   logic rstN;
   assign rstN = rstN_q;

   // Synchronised request line and its rising edge.
   logic lineSync, lineRise;
   acs_edge_sync u_acs_edge_sync (
      .core_clk  (core_clk),
      .rstN      (rstN),
      .lineIn    (calReqNIn),
      .lineSync  (lineSync),
      .risePulse (lineRise)
   );

   // Power-on hold: the open-drain driver only ever pulls low.
   logic porOe_q, porOe_d;
   always_comb begin
      porOe_d = ~(analogSupplyOk & digitalSupplyOk);
   end
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) porOe_q <= 1'b1;
      else       porOe_q <= porOe_d;
   end
   assign calReqNOut = 1'b0;
   assign calReqNOe  = porOe_q;

   // Sequencer state and the calibration timer.
   acs_state_e         state_q, state_d;
   logic [CNT_W-1:0]   calCnt_q, calCnt_d;
   logic               calEnd;
   assign calEnd = (calCnt_q == CNT_W'(CAL_CYCLES - 1));

   // A low line holds everything; the rising edge wins over any state, even run.
   always_comb begin
      state_d  = state_q;
      calCnt_d = calCnt_q;
      if (lineRise) begin
         state_d  = ACS_CAL;
         calCnt_d = '0;
      end else if (!lineSync) begin
         state_d  = ACS_HOLD;
         calCnt_d = '0;
      end else begin
         unique case (state_q)
            ACS_HOLD: state_d = ACS_HOLD;
            ACS_CAL: begin
               if (calEnd) state_d = ACS_RUN;
               else        calCnt_d = calCnt_q + CNT_W'(1);
            end
            ACS_RUN: state_d = ACS_RUN;
            default: state_d = ACS_HOLD;
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         state_q  <= ACS_HOLD;
         calCnt_q <= '0;
      end else begin
         state_q  <= state_d;
         calCnt_q <= calCnt_d;
      end
   end

   logic calDone;
   assign calDone = (state_q == ACS_RUN);

   // Register reads. While calibrating only the status register answers; other
   // reads are refused, since the core registers are not stable until the end.
   logic [7:0] rdData_q, rdData_d;
   logic       rdValid_q, rdValid_d, rdRef_q, rdRef_d;
   always_comb begin
      rdData_d  = REG_ZERO;
      rdValid_d = 1'b0;
      rdRef_d   = 1'b0;
      if (regRd) begin
         if (regAddr == CAL_STATE_ADDR) begin
            rdValid_d              = 1'b1;
            rdData_d[CAL_DONE_BIT] = calDone;
         end else if (!calDone) begin
            rdRef_d = 1'b1;
         end else begin
            rdValid_d = 1'b1;
         end
      end
   end
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         rdData_q  <= REG_ZERO;
         rdValid_q <= 1'b0;
         rdRef_q   <= 1'b0;
      end else begin
         rdData_q  <= rdData_d;
         rdValid_q <= rdValid_d;
         rdRef_q   <= rdRef_d;
      end
   end
   assign regRdData    = rdData_q;
   assign regRdValid   = rdValid_q;
   assign regRdRefused = rdRef_q;

   // Lane output: clamped samples in run, scrambler noise otherwise. Positive
   // over-range takes priority if both flags are raised at once.
   logic [SAMPLE_W-1:0] lane_q, lane_d, lfsr_q, lfsr_d;
   logic                laneValid_q, laneValid_d;
   always_comb begin
      lfsr_d      = acs_lfsr_step(lfsr_q);
      laneValid_d = calDone;
      if (!calDone)          lane_d = lfsr_q;
      else if (overRangePos) lane_d = FULL_ONES;
      else if (overRangeNeg) lane_d = FULL_ZERO;
      else                   lane_d = sampleIn;
   end
   always_ff @(posedge core_clk or negedge rstN) begin
      if (!rstN) begin
         lane_q      <= FULL_ZERO;
         lfsr_q      <= LFSR_SEED;
         laneValid_q <= 1'b0;
      end else begin
         lane_q      <= lane_d;
         lfsr_q      <= lfsr_d;
         laneValid_q <= laneValid_d;
      end
   end
   assign laneData  = lane_q;
   assign laneValid = laneValid_q;

   // Checks on the sequencing and output behaviour.
   sequence calFinish;
      (state_q == ACS_CAL) ##1 (state_q == ACS_RUN);
   endsequence
   sequence supplyLow;
      !(analogSupplyOk && digitalSupplyOk);
   endsequence

   AST_POR_HOLD: assert property (@(posedge core_clk) disable iff (!rstN)
      supplyLow |=> calReqNOe) else $error("Line not held during supply ramp.");
   AST_POR_RELEASE: assert property (@(posedge core_clk) disable iff (!rstN)
      (analogSupplyOk && digitalSupplyOk) |=> !calReqNOe && !calReqNOut)
      else $error("Line not released with good supplies.");
   AST_CAL_START: assert property (@(posedge core_clk) disable iff (!rstN)
      lineRise |=> (state_q == ACS_CAL) && (calCnt_q == '0))
      else $error("Rising edge did not start calibration.");
   AST_STATUS_BIT: assert property (@(posedge core_clk) disable iff (!rstN)
      (regRd && regAddr == CAL_STATE_ADDR) |=> regRdValid
      && (regRdData[CAL_DONE_BIT] == $past(calDone)) && (regRdData[7:1] == 7'h00))
      else $error("Status bit does not match calibration state.");
   AST_READ_GUARD: assert property (@(posedge core_clk) disable iff (!rstN)
      (regRd && regAddr != CAL_STATE_ADDR && !calDone) |=> regRdRefused && !regRdValid)
      else $error("Read during calibration was not refused.");
   AST_LANE_INVALID: assert property (@(posedge core_clk) disable iff (!rstN)
      (state_q != ACS_RUN) |=> !laneValid && (laneData == $past(lfsr_q)))
      else $error("Lanes flagged valid during calibration.");
   AST_AUTO_RESUME: assert property (@(posedge core_clk) disable iff (!rstN)
      calFinish ##0 lineSync |=> laneValid) else $error("Output did not resume.");
   AST_CAL_LENGTH: assert property (@(posedge core_clk) disable iff (!rstN)
      (state_q == ACS_CAL && calEnd && lineSync && !lineRise) |=> (state_q == ACS_RUN))
      else $error("Calibration did not end at its count.");
   AST_CAL_BOUND: assert property (@(posedge core_clk) disable iff (!rstN)
      calCnt_q <= CNT_W'(CAL_MAX_CYC)) else $error("Calibration exceeded maximum time.");
   AST_CLAMP: assert property (@(posedge core_clk) disable iff (!rstN)
      (calDone && overRangePos) |=> laneData == FULL_ONES ##0 (laneValid == 1'b1))
      else $error("Positive over-range not clamped.");
   AST_CLAMP_LOW: assert property (@(posedge core_clk) disable iff (!rstN)
      (calDone && !overRangePos && overRangeNeg) |=> laneData == FULL_ZERO)
      else $error("Negative over-range not clamped.");
   // A one-cycle high gap in a low line may leave lineSync low under the pulse, so the
   // pulse is held against the synchronised line one and two cycles back instead.
   AST_SYNC_EDGE: assert property (@(posedge core_clk) disable iff (!rstN)
      lineRise == ($past(lineSync) && !$past(lineSync, 2)))
      else $error("Edge pulse does not follow a rise of the synchronised line.");
endmodule : acs_top

// ===== acs_host_model.sv
// Host model that pulls the open-drain calibrate request line low on command.
`timescale 1ns/1ps
module acs_host_model #(
   parameter int unsigned PULL_CYCLES = 2
) (
   input  wire logic core_clk,
   input  wire logic pullStart,
   input  wire logic calReqNOe,
   output logic      calReqNLine
);
   // The model has no reset, so the counter starts idle by its declaration.
   logic [3:0] pullCnt_q = 4'h0;
   logic [3:0] pullCnt_d;

   // Two low cycles or more, so the pulse always survives the device's synchroniser.
   always_comb begin
      pullCnt_d = pullCnt_q;
      if (pullStart) begin
         pullCnt_d = 4'(PULL_CYCLES);
      end else if (pullCnt_q != 4'h0) begin
         pullCnt_d = pullCnt_q - 4'h1;
      end
   end

   // Register the pulse counter.
   always_ff @(posedge core_clk) begin
      pullCnt_q <= pullCnt_d;
   end

   // Wired line: either party pulls low, otherwise the pull-up raises it.
   assign calReqNLine = !(calReqNOe || (pullCnt_q != 4'h0));
endmodule : acs_host_model

// ===== acs_top_bench.sv
// Self-checking bench for the calibration sequencer with a host model on the request line.
`timescale 1ns/1ps
module acs_top_bench;
   import acs_pkg::*;
   localparam int unsigned CAL_N = 20;
   logic                core_clk, nrst, aOk, dOk, calLine, oe, drv, pullStart;
   logic                regRd, regRdValid, regRdRefused, overRangePos, overRangeNeg, laneValid;
   logic [7:0]          regAddr, regRdData;
   logic [SAMPLE_W-1:0] sampleIn, laneData;
   int                  failures = 0;
   int                  check_count = 0;
   int                  cycles = 0;

   acs_top #(.CAL_CYCLES(CAL_N)) u_acs_top (
      .core_clk(core_clk), .nrst(nrst), .analogSupplyOk(aOk), .digitalSupplyOk(dOk),
      .calReqNIn(calLine), .calReqNOut(drv), .calReqNOe(oe), .regRd(regRd), .regAddr(regAddr),
      .regRdData(regRdData), .regRdValid(regRdValid), .regRdRefused(regRdRefused),
      .sampleIn(sampleIn), .overRangePos(overRangePos), .overRangeNeg(overRangeNeg),
      .laneData(laneData), .laneValid(laneValid));

   acs_host_model u_acs_host_model (
      .core_clk(core_clk), .pullStart(pullStart), .calReqNOe(oe), .calReqNLine(calLine));

   // Free-running sample clock at 125 MHz.
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic give_verdict();
      $display("TB: checks=%0d mismatches=%0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : give_verdict

   // A hang is cut short well beyond two full calibrations.
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 3000) begin
         failures++;
         give_verdict();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One read: strobe for one cycle; the answer stands only in the cycle after the
   // strobe edge, so it is compared there; exp is {refused, valid, data}.
   task automatic rdReg(input logic [7:0] a, input logic [9:0] exp);
      @(negedge core_clk);
      regRd = 1'b1;
      regAddr = a;
      @(negedge core_clk);
      regRd = 1'b0;
      chk({6'h0, regRdRefused, regRdValid, regRdData}, {6'h0, exp});
   endtask : rdReg

   // Bounded wait for the lanes to reach a validity level.
   task automatic waitLane(input logic lvl, input int maxN);
      int n;
      n = 0;
      while (laneValid !== lvl && n < maxN) begin
         @(negedge core_clk);
         n++;
      end
      chk({15'h0, laneValid}, {15'h0, lvl});
   endtask : waitLane

   task automatic lane(input logic [13:0] s, input logic p, input logic n, input logic [13:0] e);
      @(negedge core_clk);
      sampleIn = s;
      overRangePos = p;
      overRangeNeg = n;
      @(negedge core_clk);
      chk({2'h0, laneData}, {2'h0, e});
   endtask : lane

   // Main sequence: power-on hold, calibration, status, clamp, recalibration.
   initial begin
      nrst = 1'b0;
      aOk = 1'b0;
      dOk = 1'b0;
      pullStart = 1'b0;
      regRd = 1'b0;
      regAddr = 8'h00;
      sampleIn = 14'h0000;
      overRangePos = 1'b0;
      overRangeNeg = 1'b0;
      repeat (2) @(negedge core_clk);
      nrst = 1'b1;
      repeat (3) @(negedge core_clk);
      chk({15'h0, calLine}, 16'h0000);
      chk({15'h0, drv}, 16'h0000);
      rdReg(CAL_STATE_ADDR, 10'h100);
      rdReg(8'h10, 10'h200);
      aOk = 1'b1;
      repeat (3) @(negedge core_clk);
      chk({15'h0, calLine}, 16'h0000);
      dOk = 1'b1;
      repeat (2) @(negedge core_clk);
      chk({15'h0, calLine}, 16'h0001);
      $display("TB: power-on test done");
      rdReg(CAL_STATE_ADDR, 10'h100);
      chk({15'h0, laneValid}, 16'h0000);
      waitLane(1'b1, 60);
      rdReg(CAL_STATE_ADDR, 10'h101);
      rdReg(8'h00, 10'h100);
      lane(14'h1234, 1'b0, 1'b0, 14'h1234);
      lane(14'h1234, 1'b1, 1'b0, FULL_ONES);
      lane(14'h1234, 1'b0, 1'b1, FULL_ZERO);
      lane(14'h0555, 1'b1, 1'b1, FULL_ONES);
      $display("TB: status and clamp test done");
      @(negedge core_clk);
      overRangePos = 1'b0;
      overRangeNeg = 1'b0;
      pullStart = 1'b1;
      @(negedge core_clk);
      pullStart = 1'b0;
      waitLane(1'b0, 20);
      rdReg(CAL_STATE_ADDR, 10'h100);
      waitLane(1'b1, 60);
      dOk = 1'b0;
      repeat (2) @(negedge core_clk);
      chk({15'h0, oe}, 16'h0001);
      $display("TB: recalibration test done");
      give_verdict();
   end
endmodule : acs_top_bench
